/* gear_select_and_travel_guard.sv */
// electronic gear selection, command scaling and travel-range guard
`timescale 1ns/100ps
`default_nettype none
module gear_select_and_travel_guard (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic servo_on,
  input wire logic full_closed_mode,
  input wire logic front_trial_run,
  input wire logic freq_resp_active,
  input wire logic comm_trial_run,
  input wire logic deviation_clear,
  input wire logic forward_overtravel_input,
  input wire logic reverse_overtravel_input,
  input wire logic speed_low,
  input wire logic gear_select_a,
  input wire logic gear_select_b,
  input wire logic cmd_pulse,
  input wire logic cmd_dir,
  input wire logic signed [31:0] motor_pos,
  output logic step_pulse,
  output logic step_dir,
  output logic alarm_stop_req,
  output logic [3:0] alarm_stop_mode,
  output logic immediate_stop,
  output logic deviation_clear_out,
  output logic irq
);
  // settings registers
  logic [3:0] alarm_seq_r;
  logic [1:0] ot_seq_r;
  logic [9:0] margin_r;
  logic [20:0] ppr_r;
  logic [30:0] num_r [4];
  logic [30:0] den_r;
  logic [30:0] enc_res_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [31:0] prdata_r;
  // datapath state
  logic [1:0] sel_idx_r;
  logic signed [40:0] acc_r;
  logic signed [31:0] cmd_pos_r;
  logic signed [31:0] span_min_r;
  logic signed [31:0] span_max_r;
  logic [37:0] margin_cnt_r;
  logic alarm_r;
  logic init_r;
  logic trial_d_r;
  logic step_r;
  logic step_dir_r;
  logic [3:0] stop_mode_r;
  logic dev_clr_r;
  gear_travel_pkg::ot_state_type ot_state_r;
  gear_travel_pkg::ot_state_type ot_state_nxt;

  // apb decode
  wire logic acc_ph = psel & penable;
  wire logic wr_en = acc_ph & pwrite;
  wire logic setup_rd = psel & ~penable & ~pwrite;
  wire logic hit_ctrl = paddr == gear_travel_pkg::OFF_CTRL;
  wire logic hit_margin = paddr == gear_travel_pkg::OFF_MARGIN;
  wire logic hit_ppr = paddr == gear_travel_pkg::OFF_PPR;
  wire logic hit_num = paddr >= gear_travel_pkg::OFF_NUM1 &&
                       paddr <= gear_travel_pkg::OFF_NUM4 && paddr[1:0] == 2'h0;
  wire logic hit_den = paddr == gear_travel_pkg::OFF_DEN;
  wire logic hit_enc = paddr == gear_travel_pkg::OFF_ENC_RES;
  wire logic hit_stat = paddr == gear_travel_pkg::OFF_STATUS;
  wire logic hit_istat = paddr == gear_travel_pkg::OFF_IRQ_STAT;
  wire logic hit_imask = paddr == gear_travel_pkg::OFF_IRQ_MASK;
  wire logic hit_cpos = paddr == gear_travel_pkg::OFF_CMD_POS;
  wire logic hit_smin = paddr == gear_travel_pkg::OFF_SPAN_MIN;
  wire logic hit_smax = paddr == gear_travel_pkg::OFF_SPAN_MAX;
  wire logic hit_aclr = paddr == gear_travel_pkg::OFF_ALM_CLR;
  wire logic addr_hit = hit_ctrl | hit_margin | hit_ppr | hit_num | hit_den |
                        hit_enc | hit_stat | hit_istat | hit_imask | hit_cpos |
                        hit_smin | hit_smax | hit_aclr;
  wire logic [7:0] num_off = paddr - gear_travel_pkg::OFF_NUM1;
  wire logic [1:0] num_widx = num_off[3:2];

  // zero wait states; unmapped addresses answer with an error
  assign pready = acc_ph;
  assign pslverr = acc_ph & ~addr_hit;
  assign prdata = prdata_r;

  // write clamping keeps every setting inside its legal range
  wire logic [9:0] margin_wr = (pwdata[31:10] != 22'h0 ||
                                pwdata[9:0] > gear_travel_pkg::MARGIN_MAX) ?
                               gear_travel_pkg::MARGIN_MAX : pwdata[9:0];
  wire logic [20:0] ppr_wr = (pwdata[31:21] != 11'h0 ||
                              pwdata[20:0] > gear_travel_pkg::PPR_MAX) ?
                             gear_travel_pkg::PPR_MAX : pwdata[20:0];
  wire logic [30:0] gear_wr = (pwdata[31] ||
                               pwdata[30:0] > gear_travel_pkg::GEAR_MAX) ?
                              gear_travel_pkg::GEAR_MAX : pwdata[30:0];
  wire logic [30:0] den_wr = (gear_wr == 31'h0000_0000) ?
                             gear_travel_pkg::DEN_MIN : gear_wr;
  // a zero resolution would null the margin and the ppr and zero-numerator ratios, so zero maps to one
  localparam logic [30:0] DEN_ONE = gear_travel_pkg::DEN_MIN;

  // settings writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alarm_seq_r <= 4'h0;
      ot_seq_r <= 2'h0;
      margin_r <= gear_travel_pkg::MARGIN_RST;
      ppr_r <= gear_travel_pkg::PPR_RST;
      den_r <= gear_travel_pkg::DEN_RST;
      enc_res_r <= gear_travel_pkg::ENC_RES_RST;
      irq_mask_r <= 3'h0;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        alarm_seq_r <= pwdata[gear_travel_pkg::CTRL_ASEQ_LSB +: gear_travel_pkg::CTRL_ASEQ_W];
        ot_seq_r <= pwdata[gear_travel_pkg::CTRL_OTS_LSB +: gear_travel_pkg::CTRL_OTS_W];
      end
      if (hit_margin) margin_r <= margin_wr;
      if (hit_ppr) ppr_r <= ppr_wr;
      if (hit_den) den_r <= den_wr;
      if (hit_enc) enc_res_r <= (gear_wr == 31'h0000_0000) ? DEN_ONE : gear_wr;
      if (hit_imask) irq_mask_r <= pwdata[2:0];
    end
  end

  // numerator bank, one word per gear slot
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) num_r[i] <= gear_travel_pkg::NUM_RST;
    end else if (wr_en && hit_num) begin
      num_r[num_widx] <= gear_wr;
    end
  end

  // read mux, sampled in the setup cycle so prdata comes from a flop
  wire logic [31:0] status_word = {26'h0, ot_state_r, sel_idx_r, immediate_stop, alarm_r};
  wire logic [31:0] rd_mux =
    hit_ctrl ? {26'h0, ot_seq_r, alarm_seq_r} :
    hit_margin ? {22'h0, margin_r} :
    hit_ppr ? {11'h0, ppr_r} :
    hit_num ? {1'b0, num_r[num_widx]} :
    hit_den ? {1'b0, den_r} :
    hit_enc ? {1'b0, enc_res_r} :
    hit_stat ? status_word :
    hit_istat ? {29'h0, irq_stat_r} :
    hit_imask ? {29'h0, irq_mask_r} :
    hit_cpos ? cmd_pos_r :
    hit_smin ? span_min_r :
    hit_smax ? span_max_r : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (sys_rst) prdata_r <= 32'h0000_0000;
    else if (setup_rd) prdata_r <= rd_mux;
  end

  // gear slot follows the select inputs only while servo is on
  wire logic [1:0] sel_idx_nxt = servo_on ?
                                 {gear_select_b, gear_select_a} : sel_idx_r;
  always_ff @(posedge clk) begin
    if (sys_rst) sel_idx_r <= 2'h0;
    else sel_idx_r <= sel_idx_nxt;
  end

  // effective ratio: ppr wins unless zero or full-closed
  wire logic [30:0] sel_num = num_r[sel_idx_r];
  wire logic use_gear = ppr_r == 21'h00_0000 || full_closed_mode;
  wire logic unity = full_closed_mode && sel_num == 31'h0000_0000;
  wire logic [30:0] num_eff = !use_gear ? enc_res_r :
                              unity ? gear_travel_pkg::GEAR_UNITY :
                              (sel_num == 31'h0000_0000) ? enc_res_r : sel_num;
  wire logic [30:0] den_eff = !use_gear ? {10'h0, ppr_r} :
                              unity ? gear_travel_pkg::GEAR_UNITY : den_r;

  // span clear sources; power-up handled by init_r
  wire logic ot_in = forward_overtravel_input | reverse_overtravel_input;
  wire logic ot_seq_imm = ot_seq_r == gear_travel_pkg::OTS_IMMEDIATE;
  wire logic trial_edge = comm_trial_run ^ trial_d_r;
  wire logic span_clr = init_r | deviation_clear | (ot_in & ot_seq_imm) | trial_edge;

  // scaling accumulator: numerator per pulse, one motor count per denominator
  // limitation: at most one count leaves per cycle, so high ratios lag
  wire logic signed [40:0] num_s = $signed({10'h0, num_eff});
  wire logic signed [40:0] den_s = $signed({10'h0, den_eff});
  wire logic take = cmd_pulse & servo_on;
  wire logic emit_fwd = acc_r >= den_s;
  wire logic emit_rev = acc_r <= -den_s;
  wire logic signed [40:0] acc_add = !take ? 41'sh0 : (cmd_dir ? -num_s : num_s);
  wire logic signed [40:0] acc_sub = emit_fwd ? den_s : (emit_rev ? -den_s : 41'sh0);
  wire logic signed [40:0] acc_nxt = span_clr ? 41'sh0 : acc_r + acc_add - acc_sub;
  wire logic emit = (emit_fwd | emit_rev) & ~span_clr;
  wire logic signed [31:0] cmd_pos_nxt = span_clr ? motor_pos :
                                         !emit ? cmd_pos_r :
                                         emit_fwd ? cmd_pos_r + 32'sh1 : cmd_pos_r - 32'sh1;

  // commands widen the span in either direction; commands are never judged
  wire logic signed [31:0] span_min_nxt = span_clr ? motor_pos :
    (cmd_pos_nxt < span_min_r) ? cmd_pos_nxt : span_min_r;
  wire logic signed [31:0] span_max_nxt = span_clr ? motor_pos :
    (cmd_pos_nxt > span_max_r) ? cmd_pos_nxt : span_max_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_r <= 41'sh0;
      cmd_pos_r <= 32'sh0;
      span_min_r <= 32'sh0;
      span_max_r <= 32'sh0;
      init_r <= 1'b1;
      trial_d_r <= 1'b0;
      step_r <= 1'b0;
      step_dir_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      cmd_pos_r <= cmd_pos_nxt;
      span_min_r <= span_min_nxt;
      span_max_r <= span_max_nxt;
      init_r <= 1'b0;
      trial_d_r <= comm_trial_run;
      step_r <= emit;
      step_dir_r <= emit ? emit_rev : step_dir_r;
    end
  end

  // margin in encoder counts: tenths of a revolution times resolution
  wire logic [40:0] margin_prod = 41'(margin_r) * 41'(enc_res_r);
  wire logic [40:0] margin_quot = margin_prod / gear_travel_pkg::MARGIN_DIV;
  wire logic [37:0] margin_cnt_nxt = margin_quot[37:0];
  always_ff @(posedge clk) begin
    if (sys_rst) margin_cnt_r <= 38'h0;
    else margin_cnt_r <= margin_cnt_nxt;
  end

  // permitted range is span plus margin on each side
  wire logic signed [39:0] margin_s = $signed({2'b00, margin_cnt_r});
  wire logic signed [39:0] pos_x = 40'(motor_pos);
  wire logic signed [39:0] hi_bound = 40'(span_max_r) + margin_s;
  wire logic signed [39:0] lo_bound = 40'(span_min_r) - margin_s;
  wire logic out_of_range = pos_x > hi_bound || pos_x < lo_bound;
  wire logic guard_on = servo_on & ~init_r &
                        ~front_trial_run & ~freq_resp_active;
  wire logic alarm_evt = guard_on & out_of_range & ~alarm_r;
  wire logic alm_clr = wr_en & hit_aclr & pwdata[0];

  // alarm latch; a new trip beats a software clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alarm_r <= 1'b0;
      stop_mode_r <= 4'h0;
    end else begin
      alarm_r <= alarm_evt | (alarm_r & ~alm_clr);
      stop_mode_r <= alarm_evt ? alarm_seq_r : stop_mode_r;
    end
  end

  // over-travel immediate stop: clear deviation entering and leaving decel
  always_comb begin
    ot_state_nxt = ot_state_r;
    unique case (ot_state_r)
      gear_travel_pkg::OT_IDLE: begin
        if (ot_in && ot_seq_imm && servo_on) ot_state_nxt = gear_travel_pkg::OT_DECEL;
      end
      gear_travel_pkg::OT_DECEL: begin
        if (speed_low) ot_state_nxt = gear_travel_pkg::OT_HELD;
      end
      gear_travel_pkg::OT_HELD: begin
        if (!ot_in) ot_state_nxt = gear_travel_pkg::OT_IDLE;
      end
      default: ot_state_nxt = gear_travel_pkg::OT_IDLE;
    endcase
  end
  wire logic ot_move = ot_state_nxt != ot_state_r && ot_state_nxt != gear_travel_pkg::OT_IDLE;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ot_state_r <= gear_travel_pkg::OT_IDLE;
      dev_clr_r <= 1'b0;
    end else begin
      ot_state_r <= ot_state_nxt;
      dev_clr_r <= ot_move;
    end
  end

  // sticky events; a read clears only bits it returned, so late sets survive
  wire logic [2:0] irq_evt = {ot_move & ot_state_nxt == gear_travel_pkg::OT_DECEL,
                              span_clr & ~init_r, alarm_evt};
  wire logic [2:0] irq_rclr = (acc_ph & ~pwrite & hit_istat) ? prdata_r[2:0] : 3'h0;
  always_ff @(posedge clk) begin
    if (sys_rst) irq_stat_r <= 3'h0;
    else irq_stat_r <= (irq_stat_r & ~irq_rclr) | irq_evt;
  end

  // outputs
  assign irq = |(irq_stat_r & irq_mask_r);
  assign step_pulse = step_r;
  assign step_dir = step_dir_r;
  assign alarm_stop_req = alarm_r;
  assign alarm_stop_mode = stop_mode_r;
  assign immediate_stop = ot_state_r == gear_travel_pkg::OT_DECEL;
  assign deviation_clear_out = dev_clr_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_guard_gating: assert property ($rose(alarm_r) |->
    $past(servo_on && !front_trial_run && !freq_resp_active))
    else $error("alarm tripped with guard disabled");
  chk_alarm_stop: assert property ($rose(alarm_r) |->
    alarm_stop_req && alarm_stop_mode == $past(alarm_seq_r))
    else $error("alarm stop mode not taken from setting");
  chk_margin_range: assert property (margin_r <= gear_travel_pkg::MARGIN_MAX)
    else $error("margin above limit");
  chk_range_trip: assert property (guard_on && out_of_range && !alarm_r |=>
    alarm_r && irq_stat_r[gear_travel_pkg::IRQ_ALARM])
    else $error("range violation did not trip");
  chk_span_clear: assert property (span_clr |=>
    span_min_r == $past(motor_pos) && span_max_r == $past(motor_pos) && acc_r == 41'sh0)
    else $error("span not reset to motor position");
  chk_span_cover: assert property (span_min_r <= cmd_pos_r && cmd_pos_r <= span_max_r)
    else $error("command position outside span");
  chk_gear_pick: assert property (servo_on && gear_select_b && !gear_select_a |=>
    sel_idx_r == 2'h2)
    else $error("wrong numerator slot");
  chk_gear_hold: assert property (!servo_on |=> $stable(sel_idx_r))
    else $error("gear changed with servo off");
  chk_ppr_ratio: assert property (!use_gear |->
    den_eff == {10'h0, ppr_r} && num_eff == enc_res_r)
    else $error("ppr ratio not applied");
  chk_zero_num: assert property (!full_closed_mode && use_gear &&
    sel_num == 31'h0000_0000 |-> num_eff == enc_res_r)
    else $error("zero numerator not replaced");
  chk_unity_ratio: assert property (unity |->
    num_eff == gear_travel_pkg::GEAR_UNITY && den_eff == gear_travel_pkg::GEAR_UNITY)
    else $error("full-closed zero numerator not unity");
  chk_den_nonzero: assert property (den_r != 31'h0000_0000)
    else $error("denominator zero");
  chk_ot_clear: assert property (ot_state_r == gear_travel_pkg::OT_DECEL && speed_low
    |=> deviation_clear_out && ot_state_r == gear_travel_pkg::OT_HELD)
    else $error("no deviation clear at decel end");
  chk_ot_entry: assert property ($rose(immediate_stop) |-> deviation_clear_out)
    else $error("no deviation clear at decel start");
  chk_alarm_hold: assert property (alarm_r && !alm_clr |=> alarm_r)
    else $error("alarm dropped without clear");
endmodule
`default_nettype wire

/* gear_select_and_travel_guard_bench.sv */
// self-checking bench for the gear select and travel guard block
`timescale 1ns/100ps
`default_nettype none
module gear_select_and_travel_guard_bench;
  typedef struct {logic fc; logic [31:0] ppr; logic [1:0] sel;
    logic [7:0] n; logic [31:0] e;} row_type;
  logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, count = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd_s;
  logic pready, pslverr, err_s, cmd_pulse, cmd_dir, ga, gb, host_busy;
  logic servo_on = 1'b0, fc = 1'b0, front = 1'b0, freq = 1'b0, comm = 1'b0, dclr = 1'b0;
  logic ot = 1'b0, speed_low = 1'b0, go = 1'b0, dir = 1'b0, slow = 1'b0;
  logic [1:0] sel = 2'h0;
  logic signed [31:0] motor_pos = 32'sh0000_0000, steps = 32'sh0000_0000, base;
  logic step_pulse, step_dir, alarm, imm, dco, irq;
  logic [3:0] amode;
  int fails = 0, samples_checked = 0, cycles = 0, dco_cnt = 0, dbase;
  // rows: full-closed, pulses per rev, selector, pulse count, expected steps
  row_type rows [7] = '{'{1'b0, 32'h0, 2'h0, 8'h03, 32'h3}, '{1'b0, 32'h0, 2'h1, 8'h03, 32'h6},
    '{1'b0, 32'h0, 2'h2, 8'h03, 32'h9}, '{1'b0, 32'h0, 2'h3, 8'h03, 32'h1e},
    '{1'b1, 32'h0, 2'h3, 8'h03, 32'h3}, '{1'b0, 32'h4, 2'h0, 8'h04, 32'ha},
    '{1'b1, 32'h4, 2'h1, 8'h04, 32'h8}};
  always #4 clk = ~clk;
  // tallies of emitted steps and deviation-clear pulses, plus the hang limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (step_pulse === 1'b1) steps <= step_dir ? steps - 1 : steps + 1;
    if (dco === 1'b1) dco_cnt <= dco_cnt + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      print_verdict();
    end
  end
  gear_select_and_travel_guard uut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .servo_on(servo_on), .full_closed_mode(fc),
    .front_trial_run(front), .freq_resp_active(freq), .comm_trial_run(comm),
    .deviation_clear(dclr), .forward_overtravel_input(ot), .reverse_overtravel_input(1'b0),
    .speed_low(speed_low), .gear_select_a(ga), .gear_select_b(gb), .cmd_pulse(cmd_pulse),
    .cmd_dir(cmd_dir), .motor_pos(motor_pos), .step_pulse(step_pulse), .step_dir(step_dir),
    .alarm_stop_req(alarm), .alarm_stop_mode(amode), .immediate_stop(imm),
    .deviation_clear_out(dco), .irq(irq));
  host_pulse_model host (.clk(clk), .sys_rst(sys_rst), .go(go), .count(count), .dir(dir),
    .sel(sel), .slow(slow), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir), .gear_select_a(ga),
    .gear_select_b(gb), .busy(host_busy));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chkb(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  // one apb transfer; request held until pready is seen at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_s = prdata;
    err_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) fails++;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // wait until the burst is over and the step backlog has drained
  task send(input logic [7:0] c, input logic d, input logic [1:0] s);
    int n;
    int q;
    n = 0;
    q = 0;
    @(posedge clk);
    go <= 1'b1;
    count <= c;
    dir <= d;
    sel <= s;
    @(posedge clk);
    go <= 1'b0;
    while (q < 6 && n < 300) begin
      @(posedge clk);
      n++;
      q = (host_busy === 1'b1 || step_pulse === 1'b1) ? 0 : q + 1;
    end
    if (n >= 300) fails++;
  endtask
  task mv(input logic signed [31:0] p, input logic e);
    motor_pos <= p;
    cyc(4);
    chkb("alarm", e, alarm);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    cyc(16);
    sys_rst <= 1'b0;
    cyc(2);
    apb(1'b0, gear_travel_pkg::OFF_DEN, 32'h0);
    chk("den_rst", 32'h0000_2710, rd_s);
    // gear table: numerators 1, 2, 3 and 0, shared denominator 1
    servo_on <= 1'b1;
    apb(1'b1, gear_travel_pkg::OFF_ENC_RES, 32'ha);
    apb(1'b1, gear_travel_pkg::OFF_DEN, 32'h1);
    for (int i = 0; i < 3; i++) apb(1'b1, gear_travel_pkg::OFF_NUM1 + 8'(4 * i), 32'(i + 1));
    apb(1'b1, gear_travel_pkg::OFF_NUM4, 32'h0);
    for (int i = 0; i < 7; i++) begin
      fc <= rows[i].fc;
      apb(1'b1, gear_travel_pkg::OFF_PPR, rows[i].ppr);
      base = steps;
      send(rows[i].n, 1'b0, rows[i].sel);
      chk("steps", rows[i].e, steps - base);
      apb(1'b0, gear_travel_pkg::OFF_STATUS, 32'h0);
      chk("slot", {30'h0, rows[i].sel}, {30'h0, rd_s[3:2]});
    end
    fc <= 1'b0;
    apb(1'b1, gear_travel_pkg::OFF_PPR, 32'h0);
    // empty span: only the margin around the motor counts
    dclr <= 1'b1;
    cyc(2);
    dclr <= 1'b0;
    apb(1'b1, gear_travel_pkg::OFF_CTRL, 32'h5);
    apb(1'b1, gear_travel_pkg::OFF_MARGIN, 32'h1);
    apb(1'b1, gear_travel_pkg::OFF_IRQ_MASK, 32'h1);
    mv(1, 1'b0);
    chkb("irq_masked", 1'b0, irq);
    mv(2, 1'b1);
    chk("stop_mode", 32'h5, {28'h0, amode});
    chkb("irq_on", 1'b1, irq);
    apb(1'b0, gear_travel_pkg::OFF_IRQ_STAT, 32'h0);
    chk("irq_status", 32'h3, rd_s);
    cyc(1);
    chkb("irq_off", 1'b0, irq);
    motor_pos <= 32'sh0;
    apb(1'b1, gear_travel_pkg::OFF_ALM_CLR, 32'h1);
    // commands both ways widen the span; slow host for the forward burst only
    slow <= 1'b1;
    send(8'h05, 1'b0, 2'h0);
    slow <= 1'b0;
    send(8'h07, 1'b1, 2'h0);
    apb(1'b0, gear_travel_pkg::OFF_SPAN_MIN, 32'h0);
    chk("span_min", 32'hffff_fffe, rd_s);
    mv(6, 1'b0);
    mv(-3, 1'b0);
    mv(7, 1'b1);
    motor_pos <= 32'sh0;
    apb(1'b1, gear_travel_pkg::OFF_ALM_CLR, 32'h1);
    // trial run and frequency measurement switch the guard off
    front <= 1'b1;
    mv(20, 1'b0);
    front <= 1'b0;
    freq <= 1'b1;
    mv(20, 1'b0);
    freq <= 1'b0;
    mv(20, 1'b1);
    comm <= 1'b1;
    cyc(3);
    comm <= 1'b0;
    apb(1'b1, gear_travel_pkg::OFF_ALM_CLR, 32'h1);
    mv(20, 1'b0);
    apb(1'b0, gear_travel_pkg::OFF_SPAN_MAX, 32'h0);
    chk("span_max", 32'h14, rd_s);
    // servo off: no pulse intake and no guard
    servo_on <= 1'b0;
    base = steps;
    send(8'h03, 1'b0, 2'h0);
    chk("steps_off", 32'h0, steps - base);
    mv(40, 1'b0);
    mv(20, 1'b0);
    servo_on <= 1'b1;
    // over-travel sequence 2: immediate stop, deviation cleared twice
    apb(1'b1, gear_travel_pkg::OFF_CTRL, 32'h20);
    dbase = dco_cnt;
    ot <= 1'b1;
    cyc(4);
    chkb("imm_stop", 1'b1, imm);
    chk("dev_clr", 32'h1, 32'(dco_cnt - dbase));
    speed_low <= 1'b1;
    cyc(4);
    chk("dev_clr", 32'h2, 32'(dco_cnt - dbase));
    chkb("imm_held", 1'b0, imm);
    ot <= 1'b0;
    speed_low <= 1'b0;
    // clamps, unmapped place, then a reset in mid-run
    apb(1'b1, gear_travel_pkg::OFF_MARGIN, 32'h7d0);
    apb(1'b0, gear_travel_pkg::OFF_MARGIN, 32'h0);
    chk("margin_max", 32'h3e8, rd_s);
    apb(1'b1, gear_travel_pkg::OFF_DEN, 32'h0);
    apb(1'b0, gear_travel_pkg::OFF_DEN, 32'h0);
    chk("den_min", 32'h1, rd_s);
    apb(1'b0, 8'h40, 32'h0);
    chkb("slverr", 1'b1, err_s);
    chk("unmapped", 32'h0, rd_s);
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(2);
    apb(1'b0, gear_travel_pkg::OFF_MARGIN, 32'h0);
    chk("margin_rst", 32'ha, rd_s);
    print_verdict();
  end
endmodule
`default_nettype wire

/* gear_travel_pkg.sv */
// shared constants for the gear select and travel guard block
`default_nettype none
package gear_travel_pkg;
  // apb byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MARGIN = 8'h04;
  localparam logic [7:0] OFF_PPR = 8'h08;
  localparam logic [7:0] OFF_NUM1 = 8'h0c;
  localparam logic [7:0] OFF_NUM4 = 8'h18;
  localparam logic [7:0] OFF_DEN = 8'h1c;
  localparam logic [7:0] OFF_ENC_RES = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;
  localparam logic [7:0] OFF_CMD_POS = 8'h30;
  localparam logic [7:0] OFF_SPAN_MIN = 8'h34;
  localparam logic [7:0] OFF_SPAN_MAX = 8'h38;
  localparam logic [7:0] OFF_ALM_CLR = 8'h3c;
  // setting limits
  localparam logic [9:0] MARGIN_MAX = 10'h3e8;
  localparam logic [20:0] PPR_MAX = 21'h10_0000;
  localparam logic [30:0] GEAR_MAX = 31'h4000_0000;
  localparam logic [30:0] DEN_MIN = 31'h0000_0001;
  localparam logic [30:0] GEAR_UNITY = 31'h0000_0001;
  localparam logic [40:0] MARGIN_DIV = 41'h000_0000_000a;
  localparam logic [1:0] OTS_IMMEDIATE = 2'h2;
  // reset values (plain defaults)
  localparam logic [30:0] ENC_RES_RST = 31'h0002_0000;
  localparam logic [30:0] NUM_RST = 31'h0000_0000;
  localparam logic [30:0] DEN_RST = 31'h0000_2710;
  localparam logic [20:0] PPR_RST = 21'h00_0000;
  localparam logic [9:0] MARGIN_RST = 10'h00a;
  // ctrl fields
  localparam int CTRL_ASEQ_LSB = 0;
  localparam int CTRL_ASEQ_W = 4;
  localparam int CTRL_OTS_LSB = 4;
  localparam int CTRL_OTS_W = 2;
  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_SPAN_CLR = 1;
  localparam int IRQ_OT_STOP = 2;
  // over-travel stop sequencer
  typedef enum logic [1:0] {
    OT_IDLE = 2'b00,
    OT_DECEL = 2'b01,
    OT_HELD = 2'b10
  } ot_state_type;
endpackage
`default_nettype wire

/* host_pulse_model.sv */
// host motion controller model: command pulse bursts and gear selectors
`timescale 1ns/100ps
`default_nettype none
module host_pulse_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic [7:0] count,
  input wire logic dir,
  input wire logic [1:0] sel,
  input wire logic slow,
  output logic cmd_pulse,
  output logic cmd_dir,
  output logic gear_select_a,
  output logic gear_select_b,
  output logic busy
);
  logic [7:0] left_r;
  logic slow_r;
  logic gap_r;
  // selectors and direction move only between bursts, so no pulse sees a half-changed gear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      left_r <= 8'h00;
      slow_r <= 1'b0;
      gap_r <= 1'b0;
      cmd_pulse <= 1'b0;
      cmd_dir <= 1'b0;
      gear_select_a <= 1'b0;
      gear_select_b <= 1'b0;
    end else begin
      cmd_pulse <= 1'b0;
      if (go && left_r == 8'h00) begin
        left_r <= count;
        slow_r <= slow;
        cmd_dir <= dir;
        gear_select_a <= sel[0];
        gear_select_b <= sel[1];
      end else if (left_r != 8'h00 && !gap_r) begin
        cmd_pulse <= 1'b1;
        left_r <= left_r - 8'h01;
        gap_r <= slow_r;
      end else begin
        gap_r <= 1'b0;
      end
    end
  end
  // slow bursts leave an idle cycle between pulses
  assign busy = (left_r != 8'h00) | cmd_pulse;
endmodule
`default_nettype wire
